// ===== verilog/tmric_top.sv
/*
 * tmric_top: interrupt status, mask and write-one-to-clear register of a
 * two-half general-purpose timer, behind an avalon-mm slave with waitrequest.
 * assumes: timer core gives one-cycle event strobes, all on clk.
 */
// How it works
// - writing one to bit 3 clears rtc match
// - writing one to bit 2 clears capture event A
// - bit 1 write-one clears capture match A
// - writing one to bit 0 clears timeout A
// - zero bits leave pending interrupts untouched
// - bits 7:4 reserved, read as zero
// - clear drops both raw and masked views
`default_nettype none

module tmric_top (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 srst,
    // avalon-mm slave
    input  wire logic [7:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [3:0]           avs_byteenable,
    input  wire logic [31:0]          avs_writedata,
    output var  logic [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    // timer core events
    input  wire tmric_pkg::tmric_evt_s evt,
    // interrupt flags toward the core and the cpu
    output logic [31:0]               raw_interrupt_status,
    output logic [31:0]               masked_interrupt_status,
    output logic                      timer_irq,
    output logic                      bus_irq
);

    tmric_pkg::tmric_req_s   req;
    tmric_pkg::tmric_state_e state_r;
    tmric_pkg::tmric_state_e state_nxt;
    logic [31:0]             wdata_be;
    logic [31:0]             rdata_nxt;
    logic [31:0]             clear_bits;
    logic [31:0]             mask_r;
    logic [tmric_pkg::SRC_N-1:0] evt_vec;
    logic [tmric_pkg::SRC_N-1:0] raw_vec;
    logic [tmric_pkg::SRC_N-1:0] clr_vec;
    logic [1:0]              irq_stat_r;
    logic [1:0]              irq_stat_nxt;
    logic [1:0]              irq_mask_r;
    logic [1:0]              irq_evt;
    logic                    raw_any_r;
    logic                    wr_take;
    logic                    rd_take;

    // decoding used for every write: byte enables applied to data
    function automatic logic [31:0] lane_data(input logic [3:0]  be,
                                               input logic [31:0] d);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return d & m;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    assign req = '{address: avs_address, read: avs_read, write: avs_write,
                   byteenable: avs_byteenable, writedata: avs_writedata};

    // one wait cycle per access; the access completes in ST_RESP
    // a request still high in ST_DONE is ignored, so a master that drops it within that one cycle never doubles up
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            tmric_pkg::ST_IDLE: begin
                if (req.read || req.write) begin
                    state_nxt = tmric_pkg::ST_RESP;
                end
            end
            tmric_pkg::ST_RESP: begin
                state_nxt = tmric_pkg::ST_DONE;
            end
            tmric_pkg::ST_DONE: begin
                state_nxt = tmric_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = tmric_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= tmric_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // master releases after the resp edge; done gives it one cycle to drop
    assign avs_waitrequest = (state_r != tmric_pkg::ST_RESP);
    assign wr_take  = (state_r == tmric_pkg::ST_RESP) && req.write;
    assign rd_take  = (state_r == tmric_pkg::ST_RESP) && req.read;
    assign wdata_be = lane_data(req.byteenable, req.writedata);

    // only ones written to defined clear bits act; reserved and zero bits do nothing
    assign clear_bits = (wr_take && hit(req.address, tmric_pkg::OFS_CLEAR))
                      ? (wdata_be & tmric_pkg::FLAG_MASK) : 32'h0000_0000;

    assign evt_vec = {evt.b_cap_match, evt.b_timeout, evt.rtc_match,
                      evt.a_cap_event, evt.a_cap_match, evt.a_timeout};
    assign clr_vec = {clear_bits[tmric_pkg::BIT_B_CAP_MATCH],
                      clear_bits[tmric_pkg::BIT_B_TIMEOUT],
                      clear_bits[tmric_pkg::BIT_RTC_MATCH],
                      clear_bits[tmric_pkg::BIT_A_CAP_EVENT],
                      clear_bits[tmric_pkg::BIT_A_CAP_MATCH],
                      clear_bits[tmric_pkg::BIT_A_TIMEOUT]};

    genvar gi;
    generate
        for (gi = 0; gi < tmric_pkg::SRC_N; gi++) begin : g_flag
            tmric_flag u_flag (
                .clk    (clk),
                .srst   (srst),
                .set    (evt_vec[gi]),
                .clr    (clr_vec[gi]),
                .flag_r (raw_vec[gi])
            );
        end
    endgenerate

    // raw view; masked view derives from it so one clear drops both
    always_comb begin
        raw_interrupt_status = tmric_pkg::RESET_STATUS;
        raw_interrupt_status[tmric_pkg::BIT_A_TIMEOUT]   = raw_vec[0];
        raw_interrupt_status[tmric_pkg::BIT_A_CAP_MATCH] = raw_vec[1];
        raw_interrupt_status[tmric_pkg::BIT_A_CAP_EVENT] = raw_vec[2];
        raw_interrupt_status[tmric_pkg::BIT_RTC_MATCH]   = raw_vec[3];
        raw_interrupt_status[tmric_pkg::BIT_B_TIMEOUT]   = raw_vec[4];
        raw_interrupt_status[tmric_pkg::BIT_B_CAP_MATCH] = raw_vec[5];
    end
    assign masked_interrupt_status = raw_interrupt_status & mask_r;
    assign timer_irq = |masked_interrupt_status;

    always_ff @(posedge clk) begin
        if (srst) begin
            mask_r <= tmric_pkg::RESET_MASK;
        end else if (wr_take && hit(req.address, tmric_pkg::OFS_MASK)) begin
            mask_r <= wdata_be & tmric_pkg::FLAG_MASK;
        end
    end

    // bus-side sticky events: [0] raw flags went from none set to some set, [1] unmapped access
    always_ff @(posedge clk) begin
        if (srst) begin
            raw_any_r <= 1'b0;
        end else begin
            raw_any_r <= |raw_vec;
        end
    end

    assign irq_evt[0] = (|raw_vec) && !raw_any_r;
    assign irq_evt[1] = (wr_take || rd_take)
                      && !hit(req.address, tmric_pkg::OFS_RAW_STATUS)
                      && !hit(req.address, tmric_pkg::OFS_MASKED_STATUS)
                      && !hit(req.address, tmric_pkg::OFS_CLEAR)
                      && !hit(req.address, tmric_pkg::OFS_MASK)
                      && !hit(req.address, tmric_pkg::OFS_IRQ_STATUS)
                      && !hit(req.address, tmric_pkg::OFS_IRQ_MASK);

    // read clears; an event in the same cycle survives the clear
    always_comb begin
        irq_stat_nxt = irq_stat_r | irq_evt;
        if (rd_take && hit(req.address, tmric_pkg::OFS_IRQ_STATUS)) begin
            irq_stat_nxt = irq_evt;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_stat_r <= 2'h0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_mask_r <= 2'h0;
        end else if (wr_take && hit(req.address, tmric_pkg::OFS_IRQ_MASK)) begin
            irq_mask_r <= wdata_be[1:0];
        end
    end

    assign bus_irq = |(irq_stat_r & irq_mask_r);

    always_comb begin
        rdata_nxt = tmric_pkg::UNMAPPED_RD;
        case (req.address)
            tmric_pkg::OFS_RAW_STATUS:    rdata_nxt = raw_interrupt_status;
            tmric_pkg::OFS_MASKED_STATUS: rdata_nxt = masked_interrupt_status;
            tmric_pkg::OFS_MASK:          rdata_nxt = mask_r;
            tmric_pkg::OFS_IRQ_STATUS:    rdata_nxt = {30'h0, irq_stat_r};
            tmric_pkg::OFS_IRQ_MASK:      rdata_nxt = {30'h0, irq_mask_r};
            // clear register is write-only; reserved bits read zero
            default:                      rdata_nxt = tmric_pkg::UNMAPPED_RD;
        endcase
    end

    // read data registered at the resp edge would be late, so it is built
    // one cycle early while waitrequest is still high
    always_ff @(posedge clk) begin
        if (srst) begin
            avs_readdata <= tmric_pkg::UNMAPPED_RD;
        end else if (state_r == tmric_pkg::ST_IDLE && req.read) begin
            avs_readdata <= rdata_nxt;
        end
    end

endmodule // tmric_top

`default_nettype wire

// ===== verilog/tmric_pkg.sv
/*
 * tmric_pkg: register offsets, field positions, reset values and carrier types
 * for the timer interrupt clear block.
 * assumes: a 32-bit avalon-mm register bus with byte addresses.
 */
`default_nettype none

package tmric_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned SRC_N  = 6;

    // byte offsets
    localparam logic [7:0] OFS_RAW_STATUS    = 8'h1c;
    localparam logic [7:0] OFS_MASKED_STATUS = 8'h20;
    localparam logic [7:0] OFS_CLEAR         = 8'h24;
    localparam logic [7:0] OFS_MASK          = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS    = 8'h50;
    localparam logic [7:0] OFS_IRQ_MASK      = 8'h54;

    // field positions shared by clear, raw, masked and mask registers
    localparam int unsigned BIT_A_TIMEOUT   = 0;
    localparam int unsigned BIT_A_CAP_MATCH = 1;
    localparam int unsigned BIT_A_CAP_EVENT = 2;
    localparam int unsigned BIT_RTC_MATCH   = 3;
    localparam int unsigned BIT_B_TIMEOUT   = 8;
    localparam int unsigned BIT_B_CAP_MATCH = 9;

    // writable and readable bits of the status layout; 7:4 stay reserved
    localparam logic [31:0] FLAG_MASK = 32'h0000_030f;

    localparam logic [31:0] RESET_STATUS = 32'h0000_0000;
    localparam logic [31:0] RESET_MASK   = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;
    localparam logic [1:0]  IRQ_FLAGS_W  = 2'h2;

    // bus request as it reaches the slave
    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } tmric_req_s;

    // per-source event strobes from the timer core
    typedef struct packed {
        logic b_cap_match;
        logic b_timeout;
        logic rtc_match;
        logic a_cap_event;
        logic a_cap_match;
        logic a_timeout;
    } tmric_evt_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RESP = 3'b010,
        ST_DONE = 3'b100
    } tmric_state_e;

endpackage : tmric_pkg

`default_nettype wire

// ===== verilog/tmric_flag.sv
/*
 * tmric_flag: one sticky raw interrupt flag with write-one-to-clear.
 * assumes: set and clear are one-cycle pulses on clk.
 */
`default_nettype none

module tmric_flag (
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // control
    input  wire logic set,
    input  wire logic clr,
    // state
    output var  logic flag_r
);

    // set beats clear so an event in the clear cycle is kept
    always_ff @(posedge clk) begin
        if (srst) begin
            flag_r <= 1'b0;
        end else if (set) begin
            flag_r <= 1'b1;
        end else if (clr) begin
            flag_r <= 1'b0;
        end
    end

endmodule // tmric_flag

`default_nettype wire

// ===== tb/tmric_properties.sv
/* tmric_properties: clear-register checks on the tmric_top ports.
   assumes: one clock, srst synchronous active high. */
`default_nettype none
module tmric_properties (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  srst,
    // bus
    input wire logic [7:0]            avs_address,
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic [3:0]            avs_byteenable,
    input wire logic [31:0]           avs_writedata,
    input wire logic [31:0]           avs_readdata,
    input wire logic                  avs_waitrequest,
    // flags
    input wire tmric_pkg::tmric_evt_s evt,
    input wire logic [31:0]           raw_interrupt_status,
    input wire logic [31:0]           masked_interrupt_status,
    input wire logic                  timer_irq,
    input wire logic                  bus_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic clr_hit;
    assign clr_hit = avs_write && !avs_waitrequest && avs_address == tmric_pkg::OFS_CLEAR;
    // a same-cycle event wins over the clear, so it is excluded
    rtc_clear_a: assert property (
        clr_hit && avs_byteenable[0] && avs_writedata[3] && !evt.rtc_match
        |=> !raw_interrupt_status[3]) else $error("rtc flag not cleared");
    event_clear_a: assert property (
        clr_hit && avs_byteenable[0] && avs_writedata[2] && !evt.a_cap_event
        |=> !raw_interrupt_status[2]) else $error("capture event flag not cleared");
    match_clear_a: assert property (
        clr_hit && avs_byteenable[0] && avs_writedata[1] && !evt.a_cap_match
        |=> !raw_interrupt_status[1]) else $error("capture match flag not cleared");
    timeout_clear_a: assert property (
        clr_hit && avs_byteenable[0] && avs_writedata[0] && !evt.a_timeout
        |=> !raw_interrupt_status[0]) else $error("timeout flag not cleared");
    zero_hold_a: assert property (
        clr_hit && avs_writedata[3:0] == 4'h0 && avs_writedata[9:8] == 2'h0
        |=> (raw_interrupt_status & $past(raw_interrupt_status)) == $past(raw_interrupt_status))
        else $error("zero write dropped a flag");
    reserved_zero_a: assert property (
        avs_read && !avs_waitrequest |-> avs_readdata[7:4] == 4'h0
        && raw_interrupt_status[7:4] == 4'h0) else $error("reserved bits not zero");
    half_b_clear_a: assert property (
        clr_hit && avs_byteenable[1] && avs_writedata[9:8] == 2'h3 && !evt.b_timeout
        && !evt.b_cap_match |=> raw_interrupt_status[9:8] == 2'h0)
        else $error("half b flags not cleared");
    masked_clear_a: assert property (
        clr_hit && avs_byteenable == 4'hf && evt == 6'h0 |=> (masked_interrupt_status
        & $past(avs_writedata) & tmric_pkg::FLAG_MASK) == 32'h0) else $error("masked kept");
    irq_level_a: assert property (timer_irq == |masked_interrupt_status)
        else $error("timer irq level wrong");
endmodule // tmric_properties
bind tmric_top tmric_properties u_props (.clk(clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .evt(evt), .raw_interrupt_status(raw_interrupt_status),
    .masked_interrupt_status(masked_interrupt_status), .timer_irq(timer_irq), .bus_irq(bus_irq));
`default_nettype wire

// ===== tb/timer_interrupt_clear_test.sv
/* timer_interrupt_clear_test: random events and clear writes over the bus.
   assumes: tmric_top with one wait cycle per access. */
`default_nettype none
module timer_interrupt_clear_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk, srst, avs_read, avs_write, avs_waitrequest, timer_irq, bus_irq;
    logic [7:0]            avs_address;
    logic [3:0]            avs_byteenable;
    logic [31:0]           avs_writedata, avs_readdata, raw_st, msk_st, exp, q, d;
    tmric_pkg::tmric_evt_s evt;
    int                    miscompares = 0, n_tests = 0, seed = 26396;
    logic [31:0]           corner [8] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h100, 32'h200,
                                          32'h0, 32'hf0};
    tmric_top DUT (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .evt(evt),
        .raw_interrupt_status(raw_st), .masked_interrupt_status(msk_st),
        .timer_irq(timer_irq), .bus_irq(bus_irq));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] spread(input logic [5:0] e);
        return {22'h0, e[5:4], 4'h0, e[3:0]};
    endfunction
    function automatic logic [31:0] lanes(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, want, seen);
        end
    endtask
    // no wait bound here: the watchdog cuts a hung slave short
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic pulse(input logic [5:0] e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= 6'h0;
        exp |= spread(e);
    endtask
    task automatic check_flags;
        bus(1'b0, tmric_pkg::OFS_RAW_STATUS, 32'h0);
        chk("raw read", q, exp);
        chk("raw port", raw_st, exp);
        bus(1'b0, tmric_pkg::OFS_MASKED_STATUS, 32'h0);
        chk("masked read", q, exp);
        chk("timer irq", {31'h0, timer_irq}, {31'h0, |exp});
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        srst = 1'b1;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        avs_byteenable = 4'hf;
        evt = 6'h0;
        exp = 32'h0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        check_flags;
        bus(1'b1, tmric_pkg::OFS_MASK, tmric_pkg::FLAG_MASK);
        // corner values first on all lanes: each single bit, nothing, reserved only
        for (int i = 0; i < 48; i++) begin
            d = (i < 8) ? corner[i] : $random(seed);
            pulse((i < 8) ? 6'h3f : 6'($random(seed)));
            avs_byteenable <= (i < 8) ? 4'hf : 4'($random(seed));
            bus(1'b1, tmric_pkg::OFS_CLEAR, d);
            exp &= ~(d & lanes(avs_byteenable));
            check_flags;
        end
        avs_byteenable <= 4'hf;
        bus(1'b0, tmric_pkg::OFS_CLEAR, 32'h0);
        chk("clear reads", q, 32'h0);
        bus(1'b0, tmric_pkg::OFS_IRQ_STATUS, 32'h0);
        bus(1'b1, tmric_pkg::OFS_IRQ_MASK, 32'h0);
        bus(1'b0, 8'hfc, 32'h0);
        chk("unmapped", q, 32'h0);
        @(posedge clk);
        chk("irq masked", {31'h0, bus_irq}, 32'h0);
        bus(1'b1, tmric_pkg::OFS_IRQ_MASK, 32'h2);
        @(posedge clk);
        chk("irq on", {31'h0, bus_irq}, 32'h1);
        bus(1'b0, tmric_pkg::OFS_IRQ_STATUS, 32'h0);
        chk("irq status", q & 32'h2, 32'h2);
        @(posedge clk);
        chk("irq cleared", {31'h0, bus_irq}, 32'h0);
        bus(1'b1, tmric_pkg::OFS_CLEAR, tmric_pkg::FLAG_MASK);
        exp = 32'h0;
        bus(1'b0, tmric_pkg::OFS_IRQ_STATUS, 32'h0);
        pulse(6'h04);
        bus(1'b0, tmric_pkg::OFS_IRQ_STATUS, 32'h0);
        chk("irq rise", q, 32'h1);
        finish_test;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        finish_test;
    end
endmodule // timer_interrupt_clear_test
`default_nettype wire
